/* File: include/bca_pkg.sv */
// bca_pkg: shared constants of the block cipher accelerator and its controller.
// assumes a single 40 MHz clock domain shared by both ends.
package bca_pkg;
	// clock and engine timing
	localparam int CLK_MHZ = 40;
	localparam int BLOCK_CYC_MAX = 1000; // cycles allowed per block
	localparam int ENC_ROUNDS = 10;
	// device register offsets (byte addresses on the link)
	localparam logic [11:0] CTRL_ADDR = 12'h540;
	localparam logic [11:0] DATA_ADDR = 12'h548;
	localparam logic [11:0] DATA_LAST_ADDR = 12'h54b;
	localparam logic [11:0] KEY_ADDR = 12'h550;
	localparam logic [11:0] KEY_LAST_ADDR = 12'h55f;
	// control register fields and reset value
	localparam int CTRL_DEC_BIT = 0;
	localparam int CTRL_INNEED_BIT = 1;
	localparam int CTRL_OUTRDY_BIT = 2;
	localparam int CTRL_CCM_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h02;
	// controller registers on apb
	localparam logic [7:0] H_CMD = 8'h00;
	localparam logic [7:0] H_WDATA = 8'h04;
	localparam logic [7:0] H_RDATA = 8'h08;
	localparam logic [7:0] H_STAT = 8'h0c;
	localparam logic [7:0] H_ISR = 8'h10;
	localparam logic [7:0] H_IMR = 8'h14;
	localparam logic [7:0] H_BIN = 8'h20;
	localparam logic [7:0] H_BOUT = 8'h30;
	// command register fields
	localparam int CMD_WRITE_BIT = 16;
	localparam int CMD_GO_BIT = 17;
	localparam int CMD_BLOCK_BIT = 18;
	// interrupt bits
	localparam int IRQ_ACC_BIT = 0;
	localparam int IRQ_BLK_BIT = 1;
endpackage

/* File: include/bca_link_if.sv */
// bca_link_if: register link between the controller and the cipher device.
// assumes both ends run on the same clock; strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface bca_link_if;
	logic [11:0] addr;
	logic wr;
	logic rd;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic ack;
	logic in_needed;
	logic out_ready;
	modport device(input addr, input wr, input rd, input wdata, output rdata, output ack,
		output in_needed, output out_ready);
	modport host(output addr, output wr, output rd, output wdata, input rdata, input ack,
		input in_needed, input out_ready);
endinterface
`default_nettype wire

/* File: hw/bca_device_end.sv */
// bca_device_end: 128-bit block cipher engine with its register file on the link.
// assumes link strobes are same-clock pulses; one round per clock.
//
// Contract
// R1 - encrypt or decrypt one 128-bit block
// R2 - block finishes well inside 1000 cycles
// R3 - processor-driven and dma feeding both supported
// R4 - software loads sixteen key bytes first
// R5 - control bit 0: one decrypts, zero encrypts
// R6 - four data window writes supply block
// R7 - four data window reads return result
// R8 - fourth write clears input-needed flag
// R9 - done sets output-ready, fourth read clears
// R10 - both flags ignore software writes
// R11 - dma mode software sets key, direction
// R12 - chaining off: result independent of history
// R13 - chaining on: previous result folded in; after a decrypt the code folds in that block's input instead
// R14 - control resets to input-needed only
// R15 - fourth write starts processing itself
// R16 - words least significant first, 32 bits
`timescale 1ns/1ps
`default_nettype none
module bca_device_end
	import bca_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register link from the controller
	bca_link_if.device link,
	// user side
	output logic block_done_ff
);
	typedef enum logic [1:0] {
		BCA_IDLE = 2'b00,
		BCA_EXPAND = 2'b01,
		BCA_ROUND = 2'b10
	} bca_state_e;

	// gf(2^8) helpers
	function automatic logic [7:0] xt(input logic [7:0] a);
		return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
	endfunction
	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) p = p ^ x;
			x = xt(x);
		end
		return p;
	endfunction
	// inverse is a^254; zero maps to zero
	function automatic logic [7:0] ginv(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h01;
		for (int i = 0; i < 7; i++) r = gmul(gmul(r, r), a);
		return gmul(r, r);
	endfunction
	function automatic logic [7:0] rl(input logic [7:0] x, input int n);
		logic [15:0] d;
		d = {x, x} << n;
		return d[15:8];
	endfunction
	// s-box computed rather than tabled to keep the source small
	function automatic logic [7:0] sbox(input logic [7:0] a, input logic inv);
		logic [7:0] x;
		x = ginv(a);
		if (inv) return ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05);
		return x ^ rl(x, 1) ^ rl(x, 2) ^ rl(x, 3) ^ rl(x, 4) ^ 8'h63;
	endfunction
	function automatic logic [127:0] sub(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		o = s;
		for (int i = 0; i < 16; i++) o[8*i +: 8] = sbox(s[8*i +: 8], inv);
		return o;
	endfunction
	function automatic logic [127:0] shr(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		o = s;
		for (int c = 0; c < 4; c++)
			for (int r = 0; r < 4; r++)
				o[8*(r+4*c) +: 8] = inv ? s[8*(r+4*((c-r+4)%4)) +: 8] : s[8*(r+4*((c+r)%4)) +: 8];
		return o;
	endfunction
	function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		logic [31:0] cf;
		logic [7:0] acc;
		o = s;
		cf = inv ? 32'h090d0b0e : 32'h01010302;
		for (int c = 0; c < 4; c++)
			for (int r = 0; r < 4; r++) begin
				acc = 8'h00;
				for (int j = 0; j < 4; j++)
					acc = acc ^ gmul(cf[8*((j-r+4)%4) +: 8], s[8*(j+4*c) +: 8]);
				o[8*(r+4*c) +: 8] = acc;
			end
		return o;
	endfunction
	function automatic logic [31:0] kcore(input logic [31:0] w, input logic [7:0] rc);
		return {sbox(w[7:0], 1'b0), sbox(w[31:24], 1'b0), sbox(w[23:16], 1'b0),
			sbox(w[15:8], 1'b0) ^ rc};
	endfunction
	function automatic logic [127:0] kfwd(input logic [127:0] k, input logic [7:0] rc);
		logic [31:0] w0;
		logic [31:0] w1;
		logic [31:0] w2;
		w0 = k[31:0] ^ kcore(k[127:96], rc);
		w1 = k[63:32] ^ w0;
		w2 = k[95:64] ^ w1;
		return {k[127:96] ^ w2, w2, w1, w0};
	endfunction
	function automatic logic [127:0] kbwd(input logic [127:0] k, input logic [7:0] rc);
		logic [31:0] w3;
		w3 = k[127:96] ^ k[95:64];
		return {w3, k[95:64] ^ k[63:32], k[63:32] ^ k[31:0], k[31:0] ^ kcore(w3, rc)};
	endfunction

	// registers
	bca_state_e st_ff;
	logic dec_ff;
	logic ccm_ff;
	logic in_need_ff;
	logic out_rdy_ff;
	logic busy_dec_ff;
	logic [127:0] key_ff;
	logic [127:0] in_ff;
	logic [127:0] out_ff;
	logic [127:0] chain_ff;
	logic [127:0] s_ff;
	logic [127:0] rk_ff;
	logic [7:0] rc_ff;
	logic [3:0] rnd_ff;
	logic [1:0] wcnt_ff;
	logic [1:0] rcnt_ff;
	logic [31:0] rdata_ff;
	logic ack_ff;

	// address decode
	wire hit_ctrl = link.addr == CTRL_ADDR;
	wire hit_data = link.addr >= DATA_ADDR && link.addr <= DATA_LAST_ADDR;
	wire hit_key = link.addr >= KEY_ADDR && link.addr <= KEY_LAST_ADDR;
	wire [3:0] key_idx = link.addr[3:0];
	// window writes only count while input is wanted, reads while output waits
	wire data_wr = link.wr && hit_data && in_need_ff; // R6
	wire data_rd = link.rd && hit_data && out_rdy_ff; // R7
	wire fourth_wr = data_wr && wcnt_ff == 2'd3;
	wire fourth_rd = data_rd && rcnt_ff == 2'd3;
	wire [127:0] blk_in = {link.wdata, in_ff[127:32]}; // R16
	wire [127:0] chain_sel = ccm_ff ? chain_ff : 128'h0; // R12 R13
	wire [7:0] ctrl_rd = {ccm_ff, 4'h0, out_rdy_ff, in_need_ff, dec_ff};

	// round datapath, one round per clock
	wire last = rnd_ff == 4'(ENC_ROUNDS);
	wire [127:0] k_next = kfwd(rk_ff, rc_ff);
	wire [127:0] k_prev = kbwd(rk_ff, rc_ff);
	wire [127:0] enc_t = shr(sub(s_ff, 1'b0), 1'b0);
	wire [127:0] enc_n = (last ? enc_t : mix(enc_t, 1'b0)) ^ k_next;
	wire [127:0] dec_t = sub(shr(s_ff, 1'b1), 1'b1) ^ k_prev;
	wire [127:0] dec_n = last ? dec_t : mix(dec_t, 1'b1);
	wire [127:0] rnd_n = busy_dec_ff ? dec_n : enc_n; // R1
	wire [127:0] result = busy_dec_ff ? rnd_n ^ chain_sel : rnd_n; // R13
	wire [7:0] rc_back = rc_ff == 8'h1b ? 8'h80 : {1'b0, rc_ff[7:1]};

	// read data mux
	wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_rd} :
		data_rd ? out_ff[32*rcnt_ff +: 32] :
		hit_key ? {24'h0, key_ff[8*key_idx +: 8]} : 32'h0;

	// software registers; status flags are not writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_ff <= 1'b0; // R14
			ccm_ff <= 1'b0;
			key_ff <= 128'h0;
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0;
		end else begin
			ack_ff <= link.wr || link.rd;
			if (link.rd) rdata_ff <= rd_mux;
			if (link.wr && hit_ctrl) begin
				dec_ff <= link.wdata[CTRL_DEC_BIT]; // R5 R10 R11
				ccm_ff <= link.wdata[CTRL_CCM_BIT];
			end
			if (link.wr && hit_key) key_ff[8*key_idx +: 8] <= link.wdata[7:0]; // R4
		end
	end

	// input side: shift words in, fourth write launches the engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_ff <= 128'h0;
			wcnt_ff <= 2'd0;
			rcnt_ff <= 2'd0;
			in_need_ff <= CTRL_RESET[CTRL_INNEED_BIT]; // R14
			out_rdy_ff <= CTRL_RESET[CTRL_OUTRDY_BIT];
		end else begin
			if (data_wr) begin
				in_ff <= blk_in;
				wcnt_ff <= wcnt_ff + 2'd1;
			end
			if (fourth_wr) in_need_ff <= 1'b0; // R8
			if (data_rd) rcnt_ff <= rcnt_ff + 2'd1;
			// both flags hand back to the input side after the last read
			if (fourth_rd) begin
				out_rdy_ff <= 1'b0; // R9
				in_need_ff <= 1'b1;
			end
			if (st_ff == BCA_ROUND && last) out_rdy_ff <= 1'b1; // R9
		end
	end

	// cipher engine: enc takes 10 cycles, dec 20 incl. key expansion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= BCA_IDLE;
			busy_dec_ff <= 1'b0;
			s_ff <= 128'h0;
			rk_ff <= 128'h0;
			rc_ff <= 8'h01;
			rnd_ff <= 4'd0;
			out_ff <= 128'h0;
			chain_ff <= 128'h0;
			block_done_ff <= 1'b0;
		end else begin
			block_done_ff <= 1'b0;
			case (st_ff)
				BCA_IDLE: begin
					if (fourth_wr) begin // R15 R3
						busy_dec_ff <= dec_ff;
						rk_ff <= key_ff;
						rc_ff <= 8'h01;
						rnd_ff <= dec_ff ? 4'd1 : 4'd1;
						s_ff <= dec_ff ? blk_in : blk_in ^ chain_sel ^ key_ff; // R13
						st_ff <= dec_ff ? BCA_EXPAND : BCA_ROUND;
					end
				end
				BCA_EXPAND: begin
					// walk to the last round key; keep the final rcon for stepping back
					rk_ff <= k_next;
					rnd_ff <= rnd_ff + 4'd1;
					if (last) begin
						s_ff <= s_ff ^ k_next;
						rnd_ff <= 4'd1;
						st_ff <= BCA_ROUND;
					end else begin
						rc_ff <= xt(rc_ff);
					end
				end
				BCA_ROUND: begin // R2
					s_ff <= rnd_n;
					rk_ff <= busy_dec_ff ? k_prev : k_next;
					rc_ff <= busy_dec_ff ? rc_back : xt(rc_ff);
					rnd_ff <= rnd_ff + 4'd1;
					if (last) begin
						out_ff <= result; // R1
						chain_ff <= busy_dec_ff ? in_ff : rnd_n; // R13
						block_done_ff <= 1'b1;
						st_ff <= BCA_IDLE;
					end
				end
				default: st_ff <= BCA_IDLE;
			endcase
		end
	end

	// link outputs straight from flops
	assign link.rdata = rdata_ff;
	assign link.ack = ack_ff;
	assign link.in_needed = in_need_ff; // R8
	assign link.out_ready = out_rdy_ff; // R9
endmodule
`default_nettype wire

/* File: hw/bca_host_end.sv */
// bca_host_end: apb-controlled master of the cipher link, single access or dma block.
// assumes apb on the same clock; device answers every strobe with an ack.
`timescale 1ns/1ps
`default_nettype none
module bca_host_end
	import bca_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// link to the cipher device
	bca_link_if.host link
);
	typedef enum logic [2:0] {
		BCA_H_IDLE = 3'b000,
		BCA_H_ONE = 3'b001,
		BCA_H_FEED = 3'b010,
		BCA_H_WAIT = 3'b011,
		BCA_H_DRAIN = 3'b100
	} bca_hstate_e;

	bca_hstate_e st_ff;
	logic [31:0] cmd_ff;
	logic [31:0] wdat_ff;
	logic [31:0] rdat_ff;
	logic [1:0] isr_ff;
	logic [1:0] imr_ff;
	logic [31:0] bin_ff [4];
	logic [31:0] bout_ff [4];
	logic [1:0] idx_ff;
	logic pend_ff;
	logic [11:0] addr_ff;
	logic wr_ff;
	logic rd_ff;
	logic [31:0] lwdata_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic irq_ff;

	// apb decode; setup cycle prepares answer, access cycle completes
	wire setup = psel && !penable;
	wire acc_wr = psel && penable && pready_ff && pwrite;
	wire idle = st_ff == BCA_H_IDLE;
	wire go_one = acc_wr && paddr == H_CMD && pwdata[CMD_GO_BIT] && idle;
	wire go_blk = acc_wr && paddr == H_CMD && pwdata[CMD_BLOCK_BIT] && idle;
	wire is_bin = paddr[7:4] == H_BIN[7:4] && paddr[1:0] == 2'b00;
	wire is_bout = paddr[7:4] == H_BOUT[7:4] && paddr[1:0] == 2'b00;
	wire mapped = paddr == H_CMD || paddr == H_WDATA || paddr == H_RDATA || paddr == H_STAT ||
		paddr == H_ISR || paddr == H_IMR || is_bin || is_bout;
	wire [31:0] rd_mux = paddr == H_CMD ? cmd_ff : paddr == H_WDATA ? wdat_ff :
		paddr == H_RDATA ? rdat_ff :
		paddr == H_STAT ? {29'h0, link.out_ready, link.in_needed, !idle} :
		paddr == H_ISR ? {30'h0, isr_ff} : paddr == H_IMR ? {30'h0, imr_ff} :
		is_bin ? bin_ff[paddr[3:2]] : is_bout ? bout_ff[paddr[3:2]] : 32'h0;
	// events this cycle; a set beats a same-cycle write-one clear
	wire ev_acc = st_ff == BCA_H_ONE && link.ack;
	wire ev_blk = st_ff == BCA_H_DRAIN && pend_ff && link.ack && idx_ff == 2'd3;
	wire [1:0] w1c = acc_wr && paddr == H_ISR ? pwdata[1:0] : 2'b00;
	wire [1:0] nxt_isr = (isr_ff & ~w1c) | {ev_blk, ev_acc};

	// apb answer and software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			cmd_ff <= 32'h0;
			wdat_ff <= 32'h0;
			imr_ff <= 2'b00;
			isr_ff <= 2'b00;
			irq_ff <= 1'b0;
			for (int i = 0; i < 4; i++) bin_ff[i] <= 32'h0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup && !mapped;
			if (setup) prdata_ff <= rd_mux;
			if (acc_wr && paddr == H_CMD) cmd_ff <= pwdata & 32'h0001_0fff;
			if (acc_wr && paddr == H_WDATA) wdat_ff <= pwdata;
			if (acc_wr && paddr == H_IMR) imr_ff <= pwdata[1:0];
			if (acc_wr && is_bin) bin_ff[paddr[3:2]] <= pwdata;
			isr_ff <= nxt_isr;
			irq_ff <= |(nxt_isr & imr_ff);
		end
	end

	// link sequencer; strobes are one-cycle pulses, one access outstanding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= BCA_H_IDLE;
			idx_ff <= 2'd0;
			pend_ff <= 1'b0;
			addr_ff <= 12'h0;
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			lwdata_ff <= 32'h0;
			rdat_ff <= 32'h0;
			for (int i = 0; i < 4; i++) bout_ff[i] <= 32'h0;
		end else begin
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			case (st_ff)
				BCA_H_IDLE: begin
					idx_ff <= 2'd0;
					pend_ff <= 1'b0;
					if (go_one) begin
						addr_ff <= pwdata[11:0];
						wr_ff <= pwdata[CMD_WRITE_BIT];
						rd_ff <= !pwdata[CMD_WRITE_BIT];
						lwdata_ff <= wdat_ff;
						st_ff <= BCA_H_ONE;
					end else if (go_blk) begin
						st_ff <= BCA_H_FEED;
					end
				end
				BCA_H_ONE: begin
					if (link.ack) begin
						rdat_ff <= link.rdata;
						st_ff <= BCA_H_IDLE;
					end
				end
				// dma feed: lowest word first, only while the device wants input
				BCA_H_FEED: begin // R6 R16
					if (!pend_ff && link.in_needed) begin
						addr_ff <= DATA_ADDR;
						wr_ff <= 1'b1;
						lwdata_ff <= bin_ff[idx_ff];
						pend_ff <= 1'b1;
					end else if (pend_ff && link.ack) begin
						pend_ff <= 1'b0;
						idx_ff <= idx_ff + 2'd1;
						if (idx_ff == 2'd3) st_ff <= BCA_H_WAIT;
					end
				end
				BCA_H_WAIT: begin
					if (link.out_ready) st_ff <= BCA_H_DRAIN; // R9
				end
				BCA_H_DRAIN: begin // R7
					if (!pend_ff) begin
						addr_ff <= DATA_ADDR;
						rd_ff <= 1'b1;
						pend_ff <= 1'b1;
					end else if (link.ack) begin
						bout_ff[idx_ff] <= link.rdata;
						pend_ff <= 1'b0;
						idx_ff <= idx_ff + 2'd1;
						if (idx_ff == 2'd3) st_ff <= BCA_H_IDLE;
					end
				end
				default: st_ff <= BCA_H_IDLE;
			endcase
		end
	end

	// outputs from flops
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;
	assign link.addr = addr_ff;
	assign link.wr = wr_ff;
	assign link.rd = rd_ff;
	assign link.wdata = lwdata_ff;
endmodule
`default_nettype wire

/* File: bench/bca_link_asserts.sv */
// bca_link_asserts: handshake and flag checks on the cipher link.
// assumes one clock domain; sees only the signals of the link interface.
`timescale 1ns/1ps
`default_nettype none
module bca_link_asserts
	import bca_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link signals
	input wire logic [11:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] wdata,
	input wire logic [31:0] rdata,
	input wire logic ack,
	input wire logic in_needed,
	input wire logic out_ready
);
	logic [1:0] wcnt_ff;
	logic [1:0] rcnt_ff;
	// window decode; only accesses the device takes are counted
	wire logic win = addr >= DATA_ADDR && addr <= DATA_LAST_ADDR;
	wire logic stb = wr | rd;
	wire logic wr_take = wr && win && in_needed;
	wire logic rd_take = rd && win && out_ready;
	// words of the current block so far, wraps after the fourth
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wcnt_ff <= 2'h0;
			rcnt_ff <= 2'h0;
		end else begin
			wcnt_ff <= wcnt_ff + {1'b0, wr_take};
			rcnt_ff <= rcnt_ff + {1'b0, rd_take};
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_reset_flags: assert property ($rose(presetn) |-> in_needed && !out_ready && !ack)
		else $error("flags wrong after reset");
	a_ack_follows: assert property (stb |=> ack)
		else $error("strobe not acknowledged next cycle");
	a_ack_caused: assert property (ack |-> $past(stb))
		else $error("ack without a strobe");
	a_fourth_write: assert property (wr_take && wcnt_ff == 2'h3 |=> !in_needed)
		else $error("input flag kept after fourth write");
	a_early_write: assert property (wr_take && wcnt_ff != 2'h3 |=> in_needed && !out_ready)
		else $error("input flag dropped early");
	a_done_bound: assert property ($fell(in_needed) |-> ##[1:1000] $rose(out_ready))
		else $error("block not done in time");
	a_fourth_read: assert property (rd_take && rcnt_ff == 2'h3 |=> !out_ready && in_needed)
		else $error("output flag kept after fourth read");
	a_early_read: assert property (rd_take && rcnt_ff != 2'h3 |=> out_ready)
		else $error("output flag dropped early");
	a_refused_read: assert property (rd && win && !out_ready |=> ack && rdata == 32'h0)
		else $error("window read without result gave data");
	a_ctrl_readonly: assert property (wr && addr == CTRL_ADDR |=> $stable(in_needed) && $stable(out_ready))
		else $error("control write moved a flag");
	a_flags_apart: assert property (!(in_needed && out_ready))
		else $error("both flags set");
endmodule
`default_nettype wire

/* File: bench/test_block_cipher_accelerator.sv */
// test_block_cipher_accelerator: both ends joined by the link, driven over apb.
// assumes one clock; the apb master waits for pready however many cycles it takes.
`timescale 1ns/1ps
`default_nettype none
module test_block_cipher_accelerator import bca_pkg::*;;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic [31:0] m;} bca_row_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, done;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic e;
	logic [127:0] ct, r;
	logic [127:0] pt = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0;
	int miscompares = 0;
	int n_compared = 0;
	int n_done = 0;
	// register rows: address, written value, expected readback, mask
	bca_row_s rows [6] = '{'{CTRL_ADDR, 32'h07, 32'h03, 32'h87}, '{CTRL_ADDR, 32'h80, 32'h82, 32'h87},
		'{CTRL_ADDR, 32'h06, 32'h02, 32'hff}, '{KEY_ADDR, 32'ha5, 32'ha5, 32'hff},
		'{KEY_LAST_ADDR, 32'h3c, 32'h3c, 32'hff}, '{12'h560, 32'hff, 32'h00, 32'hffffffff}};
	bca_link_if link();
	bca_device_end u_bca_device_end(.pclk(pclk), .presetn(presetn), .link(link), .block_done_ff(done));
	bca_host_end u_bca_host_end(.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.link(link));
	bca_link_asserts u_bca_link_asserts(.pclk(pclk), .presetn(presetn), .addr(link.addr), .wr(link.wr),
		.rd(link.rd), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .in_needed(link.in_needed),
		.out_ready(link.out_ready));
	// 40 mhz clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// block-done pulses, held later against the number of blocks run
	always @(posedge pclk)
		if (done === 1'b1) n_done <= n_done + 1;
	task automatic end_of_test;
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input string name, input logic [127:0] got, input logic [127:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one apb transfer; answer taken at the rising edge that sees pready high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd_q,
		output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd_q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// poll a status bit, bounded
	task automatic wait_stat(input int b, input logic v);
		logic [31:0] s;
		logic x;
		int n;
		n = 0;
		do begin
			apb(1'b0, H_STAT, 32'h0, s, x);
			n++;
		end while (s[b] !== v && n < 200);
		check("status poll", s[b], v);
	endtask
	task automatic dev_wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] s;
		logic x;
		apb(1'b1, H_WDATA, d, s, x);
		apb(1'b1, H_CMD, {14'h0, 2'h3, 4'h0, a}, s, x);
		wait_stat(0, 1'b0);
	endtask
	task automatic dev_rd(input logic [11:0] a, output logic [31:0] d);
		logic x;
		apb(1'b1, H_CMD, {14'h0, 2'h2, 4'h0, a}, d, x);
		wait_stat(0, 1'b0);
		apb(1'b0, H_RDATA, 32'h0, d, x);
	endtask
	// whole block through the host's own sequencer
	task automatic blk(input logic [127:0] din, output logic [127:0] dout);
		logic [31:0] s;
		logic x;
		for (int i = 0; i < 4; i++)
			apb(1'b1, H_BIN + 8'(4 * i), din[32 * i +: 32], s, x);
		apb(1'b1, H_CMD, 32'h0004_0000, s, x);
		wait_stat(0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, H_BOUT + 8'(4 * i), 32'h0, s, x);
			dout[32 * i +: 32] = s;
		end
	endtask
	// watchdog, far beyond the several hundred cycles the tests need
	initial begin
		repeat (30000) @(posedge pclk);
		miscompares++;
		end_of_test;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, H_STAT, 32'h0, q, e);
		check("stat after reset", q[2:0], 3'h2);
		dev_rd(CTRL_ADDR, q);
		check("ctrl after reset", q[7:0], 8'h02);
		foreach (rows[i]) begin
			dev_wr(rows[i].a, rows[i].d);
			dev_rd(rows[i].a, q);
			check("register row", q & rows[i].m, rows[i].e);
		end
		dev_rd(12'h549, q);
		check("early window read", q, 32'h0);
		apb(1'b0, 8'h40, 32'h0, q, e);
		check("apb unmapped error", e, 1'b1);
		for (int i = 0; i < 16; i++)
			dev_wr(KEY_ADDR + 12'(i), {24'h0, 8'h3b ^ 8'(i * 29)});
		dev_wr(CTRL_ADDR, 32'h0);
		// processor-driven encrypt; no start command is ever given
		for (int i = 0; i < 4; i++) begin
			dev_wr(DATA_ADDR + 12'(i), pt[32 * i +: 32]);
			apb(1'b0, H_STAT, 32'h0, q, e);
			check("input flag", q[1], i < 3);
		end
		wait_stat(2, 1'b1);
		for (int i = 0; i < 4; i++) begin
			dev_rd(DATA_ADDR + 12'(i), q);
			ct[32 * i +: 32] = q;
		end
		apb(1'b0, H_STAT, 32'h0, q, e);
		check("flags after reads", q[2:0], 3'h2);
		apb(1'b0, H_ISR, 32'h0, q, e);
		check("access event", q[0], 1'b1);
		@(negedge pclk);
		check("irq masked", irq, 1'b0);
		dev_wr(CTRL_ADDR, 32'h1);
		blk(ct, r);
		check("decrypt block", r, pt);
		dev_wr(CTRL_ADDR, 32'h0);
		apb(1'b1, H_ISR, 32'h3, q, e);
		apb(1'b1, H_IMR, 32'h2, q, e);
		blk(pt, r);
		check("dma encrypt", r, ct);
		@(negedge pclk);
		check("irq raised", irq, 1'b1);
		apb(1'b1, H_ISR, 32'h2, q, e);
		apb(1'b0, H_ISR, 32'h0, q, e);
		check("isr cleared", q[1], 1'b0);
		@(negedge pclk);
		check("irq cleared", irq, 1'b0);
		dev_wr(CTRL_ADDR, 32'h80);
		blk(pt, r);
		check("chained result", r === ct, 1'b0);
		check("done pulses", n_done, 32'd4);
		// second reset once the last block is done, with chaining still set
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		dev_rd(CTRL_ADDR, q);
		check("ctrl after second reset", q[7:0], 8'h02);
		end_of_test;
	end
endmodule
`default_nettype wire
